// ### dtc_defs.svh
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH

// register byte offsets on the bus
`define DTC_OFS_MODE        8'h00
`define DTC_OFS_CTRL        8'h04
`define DTC_OFS_LOW_T0      8'h08
`define DTC_OFS_HIGH_T0     8'h0C
`define DTC_OFS_LOW_T1      8'h10
`define DTC_OFS_HIGH_T1     8'h14

// mode register field positions, per timer nibble
`define DTC_MODE_T0_LSB     0
`define DTC_MODE_T1_LSB     4
`define DTC_NIB_GATE        3
`define DTC_NIB_FUNC        2
`define DTC_NIB_MODE_HI     1
`define DTC_NIB_MODE_LO     0

// control register field positions
`define DTC_CTRL_RUN_T0     4
`define DTC_CTRL_FLAG_T0    5
`define DTC_CTRL_RUN_T1     6
`define DTC_CTRL_FLAG_T1    7

// reset values
`define DTC_RST_MODE        8'h00
`define DTC_RST_COUNT       8'h00

// machine cycle timing in oscillator periods (core clocks)
`define DTC_MC_PERIODS      12
`define DTC_PHASE_S3P1      4
`define DTC_PHASE_S5P2      9

`endif

// ### dtc_pkg.sv
`default_nettype none
package dtc_pkg;

  // operating mode of one timer, in mode bit order
  typedef enum logic [1:0] {
    DTC_MODE_13BIT,
    DTC_MODE_16BIT,
    DTC_MODE_RELOAD,
    DTC_MODE_SPLIT
  } dtc_mode_e;

  typedef logic [7:0] dtc_byte_t;

endpackage
`default_nettype wire

// ### dtc_core.sv
// Implementation choices: the placing of the registers and register access over AHB-Lite.
`include "dtc_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module dtc_core #(
  parameter int unsigned MC_LEN = `DTC_MC_PERIODS
) (
  input  wire logic          SYS_CLK_I,
  input  wire logic          RESET_I,
  // ahb-lite slave
  input  wire logic          HSEL_I,
  input  wire logic [31:0]   HADDR_I,
  input  wire logic [1:0]    HTRANS_I,
  input  wire logic          HWRITE_I,
  input  wire logic [2:0]    HSIZE_I,
  input  wire logic [31:0]   HWDATA_I,
  input  wire logic          HREADY_I,
  output var  logic [31:0]   HRDATA_O,
  output var  logic          HREADYOUT_O,
  output var  logic          HRESP_O,
  // external count and gate pins
  input  wire logic          COUNT_PIN_T0_I,
  input  wire logic          COUNT_PIN_T1_I,
  input  wire logic          GATE_PIN_T0_I,
  input  wire logic          GATE_PIN_T1_I,
  // vectoring acknowledge from the interrupt logic
  input  wire logic          VECTOR_ACK_T0_I,
  input  wire logic          VECTOR_ACK_T1_I,
  // overflow flags
  output var  logic          OVERFLOW_FLAG_T0_O,
  output var  logic          OVERFLOW_FLAG_T1_O
);
  import dtc_pkg::*;

  localparam logic [3:0] PHASE_LAST = 4'(MC_LEN - 1);
  localparam logic [3:0] PHASE_CNT  = 4'(`DTC_PHASE_S3P1);
  localparam logic [3:0] PHASE_SMP  = 4'(`DTC_PHASE_S5P2);

  logic [3:0]  phase;
  logic        tick_count;
  logic        tick_sample;
  logic [7:0]  timer_mode_reg;
  logic        run_bit_t0;
  logic        run_bit_t1;
  logic        overflow_flag_t0;
  logic        overflow_flag_t1;
  dtc_byte_t   count_low_t0;
  dtc_byte_t   count_high_t0;
  dtc_byte_t   count_low_t1;
  dtc_byte_t   count_high_t1;
  logic        sample_t0;
  logic        sample_t1;
  logic        fall_t0;
  logic        fall_t1;
  logic [3:0]  cfg_t0;
  logic [3:0]  cfg_t1;
  dtc_mode_e   mode_t0;
  dtc_mode_e   mode_t1;
  logic        split_t0;
  logic        event_t0;
  logic        event_t1;
  logic        event_high_t0;
  logic        run_eff_t1;
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic        addr_valid;
  logic [31:0] rd_mux;
  logic        wr_mode;
  logic        wr_ctrl;
  logic        wr_low_t0;
  logic        wr_high_t0;
  logic        wr_low_t1;
  logic        wr_high_t1;
  dtc_byte_t   wr_byte;
  dtc_byte_t   next_low_t0;
  dtc_byte_t   next_high_t0;
  dtc_byte_t   next_low_t1;
  dtc_byte_t   next_high_t1;
  logic        set_flag_t0;
  logic        set_flag_t1;
  logic [16:0] step_t0;
  logic [16:0] step_t1;

  // one increment of a timer in the given mode: {overflow, high, low}
  function automatic logic [16:0] count_step(
    input dtc_mode_e mode,
    input dtc_byte_t lo,
    input dtc_byte_t hi
  );
    logic [5:0] pre;
    logic [8:0] hi_sum;
    logic [8:0] lo_sum;
    logic [16:0] res;
    pre    = {1'b0, lo[4:0]} + 6'h01;
    hi_sum = {1'b0, hi} + 9'h001;
    lo_sum = {1'b0, lo} + 9'h001;
    res    = {1'b0, hi, lo};
    case (mode)
      DTC_MODE_13BIT:
      begin
        // five-bit prescaler carries into high byte
        res[7:0] = {lo[7:5], pre[4:0]};
        if (pre[5])
        begin
          res[16:8] = hi_sum;
        end
      end
      DTC_MODE_16BIT:
      begin
        res = {1'b0, hi, lo} + 17'h0_0001;
      end
      DTC_MODE_RELOAD:
      begin
        if (lo == 8'hFF)
        begin
          res = {1'b1, hi, hi};
        end
        else
        begin
          res[7:0] = lo_sum[7:0];
        end
      end
      DTC_MODE_SPLIT:
      begin
        res = {lo_sum[8], hi, lo_sum[7:0]};
      end
      default:
      begin
        res = {1'b0, hi, lo};
      end
    endcase
    return res;
  endfunction

  // machine cycle phase divider
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
      phase <= 4'h0;
    else if (phase == PHASE_LAST)
      phase <= 4'h0;
    else
      phase <= phase + 4'h1;
  end

  // one count slot per machine cycle, at S3P1; pins sampled at S5P2
  assign tick_count  = (phase == PHASE_CNT);
  assign tick_sample = (phase == PHASE_SMP);

  // count pin sampling and falling edge detect, held until next sample
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
    begin
      sample_t0 <= 1'b0;
      sample_t1 <= 1'b0;
      fall_t0   <= 1'b0;
      fall_t1   <= 1'b0;
    end
    else if (tick_sample)
    begin
      sample_t0 <= COUNT_PIN_T0_I;
      sample_t1 <= COUNT_PIN_T1_I;
      fall_t0   <= sample_t0 & ~COUNT_PIN_T0_I;
      fall_t1   <= sample_t1 & ~COUNT_PIN_T1_I;
    end
  end

  // per-timer configuration nibbles
  assign cfg_t0   = timer_mode_reg[`DTC_MODE_T0_LSB +: 4];
  assign cfg_t1   = timer_mode_reg[`DTC_MODE_T1_LSB +: 4];
  assign mode_t0  = dtc_mode_e'(cfg_t0[`DTC_NIB_MODE_HI:`DTC_NIB_MODE_LO]);
  assign mode_t1  = dtc_mode_e'(cfg_t1[`DTC_NIB_MODE_HI:`DTC_NIB_MODE_LO]);
  assign split_t0 = (mode_t0 == DTC_MODE_SPLIT);

  // while timer 0 is split, timer 1 runs outside its own mode 3
  assign run_eff_t1 = split_t0 ? 1'b1 : run_bit_t1;

  // count enables: run, gate, function select
  assign event_t0 = tick_count & run_bit_t0
                  & (~cfg_t0[`DTC_NIB_GATE] | GATE_PIN_T0_I)
                  & (cfg_t0[`DTC_NIB_FUNC] ? fall_t0 : 1'b1);
  assign event_t1 = tick_count & run_eff_t1
                  & (mode_t1 != DTC_MODE_SPLIT)
                  & (~cfg_t1[`DTC_NIB_GATE] | GATE_PIN_T1_I)
                  & (cfg_t1[`DTC_NIB_FUNC] ? fall_t1 : 1'b1);
  // split high byte counts machine cycles under timer 1 run bit
  assign event_high_t0 = tick_count & split_t0 & run_bit_t1;

  assign step_t0 = count_step(mode_t0, count_low_t0, count_high_t0);
  assign step_t1 = count_step(mode_t1, count_low_t1, count_high_t1);

  // bus write strobes during the data phase
  assign wr_byte    = HWDATA_I[7:0];
  assign wr_mode    = wr_pend & (wr_addr == `DTC_OFS_MODE);
  assign wr_ctrl    = wr_pend & (wr_addr == `DTC_OFS_CTRL);
  assign wr_low_t0  = wr_pend & (wr_addr == `DTC_OFS_LOW_T0);
  assign wr_high_t0 = wr_pend & (wr_addr == `DTC_OFS_HIGH_T0);
  assign wr_low_t1  = wr_pend & (wr_addr == `DTC_OFS_LOW_T1);
  assign wr_high_t1 = wr_pend & (wr_addr == `DTC_OFS_HIGH_T1);

  // next count values and overflow events
  always_comb
  begin
    next_low_t0  = count_low_t0;
    next_high_t0 = count_high_t0;
    next_low_t1  = count_low_t1;
    next_high_t1 = count_high_t1;
    set_flag_t0  = 1'b0;
    set_flag_t1  = 1'b0;
    if (event_t0)
    begin
      next_low_t0  = step_t0[7:0];
      next_high_t0 = step_t0[15:8];
      set_flag_t0  = step_t0[16];
    end
    if (event_high_t0)
    begin
      next_high_t0 = count_high_t0 + 8'h01;
      set_flag_t1  = (count_high_t0 == 8'hFF);
    end
    if (event_t1)
    begin
      next_low_t1  = step_t1[7:0];
      next_high_t1 = step_t1[15:8];
      // timer 1 loses its flag to the split high byte
      set_flag_t1  = set_flag_t1 | (step_t1[16] & ~split_t0);
    end
    // software write wins over hardware in the same cycle
    if (wr_low_t0)
      next_low_t0 = wr_byte;
    if (wr_high_t0)
      next_high_t0 = wr_byte;
    if (wr_low_t1)
      next_low_t1 = wr_byte;
    if (wr_high_t1)
      next_high_t1 = wr_byte;
  end

  // count registers; run changes never touch them
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
    begin
      count_low_t0  <= `DTC_RST_COUNT;
      count_high_t0 <= `DTC_RST_COUNT;
      count_low_t1  <= `DTC_RST_COUNT;
      count_high_t1 <= `DTC_RST_COUNT;
    end
    else
    begin
      count_low_t0  <= next_low_t0;
      count_high_t0 <= next_high_t0;
      count_low_t1  <= next_low_t1;
      count_high_t1 <= next_high_t1;
    end
  end

  // mode register and run bits, software only
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
    begin
      timer_mode_reg <= `DTC_RST_MODE;
      run_bit_t0     <= 1'b0;
      run_bit_t1     <= 1'b0;
    end
    else
    begin
      if (wr_mode)
        timer_mode_reg <= wr_byte;
      if (wr_ctrl)
      begin
        run_bit_t0 <= wr_byte[`DTC_CTRL_RUN_T0];
        run_bit_t1 <= wr_byte[`DTC_CTRL_RUN_T1];
      end
    end
  end

  // overflow flags: vector ack or write clears, hardware set wins
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
    begin
      overflow_flag_t0 <= 1'b0;
      overflow_flag_t1 <= 1'b0;
    end
    else
    begin
      overflow_flag_t0 <= set_flag_t0
        | (~VECTOR_ACK_T0_I
           & (wr_ctrl ? wr_byte[`DTC_CTRL_FLAG_T0] : overflow_flag_t0));
      overflow_flag_t1 <= set_flag_t1
        | (~VECTOR_ACK_T1_I
           & (wr_ctrl ? wr_byte[`DTC_CTRL_FLAG_T1] : overflow_flag_t1));
    end
  end

  assign OVERFLOW_FLAG_T0_O = overflow_flag_t0;
  assign OVERFLOW_FLAG_T1_O = overflow_flag_t1;

  // address phase decode
  assign addr_valid = HSEL_I & HTRANS_I[1] & HREADY_I;

  // read mux on the address phase address; unmapped reads zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (HADDR_I[7:0])
      `DTC_OFS_MODE:    rd_mux[7:0] = timer_mode_reg;
      `DTC_OFS_CTRL:
      begin
        rd_mux[`DTC_CTRL_RUN_T0]  = run_bit_t0;
        rd_mux[`DTC_CTRL_FLAG_T0] = overflow_flag_t0;
        rd_mux[`DTC_CTRL_RUN_T1]  = run_bit_t1;
        rd_mux[`DTC_CTRL_FLAG_T1] = overflow_flag_t1;
      end
      `DTC_OFS_LOW_T0:  rd_mux[7:0] = count_low_t0;
      `DTC_OFS_HIGH_T0: rd_mux[7:0] = count_high_t0;
      `DTC_OFS_LOW_T1:  rd_mux[7:0] = count_low_t1;
      `DTC_OFS_HIGH_T1: rd_mux[7:0] = count_high_t1;
      default:          rd_mux = 32'h0000_0000;
    endcase
    if (HADDR_I[31:8] != 24'h00_0000)
      rd_mux = 32'h0000_0000;
  end

  // ahb-lite slave: zero wait states, always okay
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
    begin
      wr_pend     <= 1'b0;
      wr_addr     <= 8'h00;
      HRDATA_O    <= 32'h0000_0000;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end
    else
    begin
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
      wr_pend     <= addr_valid & HWRITE_I
                   & (HADDR_I[31:8] == 24'h00_0000);
      if (addr_valid)
      begin
        wr_addr <= HADDR_I[7:0];
        if (!HWRITE_I)
          HRDATA_O <= rd_mux;
      end
    end
  end

endmodule // dtc_core
`default_nettype wire

// ### dummy_end_marker_unused.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ### dtc_core_chk.sv
`timescale 1ns/100ps
`default_nettype none
module dtc_core_chk (
  input  wire logic        SYS_CLK_I,
  input  wire logic        RESET_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic        HREADY_I,
  input  wire logic        VECTOR_ACK_T0_I,
  input  wire logic        VECTOR_ACK_T1_I,
  input  wire logic [31:0] HRDATA_O,
  input  wire logic        HREADYOUT_O,
  input  wire logic        HRESP_O,
  input  wire logic        OVERFLOW_FLAG_T0_O,
  input  wire logic        OVERFLOW_FLAG_T1_O
);
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (RESET_I);
  logic tk;
  logic rd_q;
  logic bad_q;
  logic wctl_q;
  // address phase taken this cycle
  assign tk = HSEL_I && HTRANS_I[1] && HREADY_I && !RESET_I;
  // data phase markers for reads and control writes
  always_ff @(posedge SYS_CLK_I)
  begin
    rd_q   <= tk && !HWRITE_I;
    bad_q  <= tk && !HWRITE_I
              && (HADDR_I > 32'h0000_0014 || HADDR_I[1:0] != 2'b00);
    wctl_q <= tk && HWRITE_I && HADDR_I == 32'h0000_0004;
  end
  // no hardware flag rise for the next eight cycles
  sequence quiet_t0;
    (!$rose(OVERFLOW_FLAG_T0_O))[*8];
  endsequence
  chk_ready_always: assert property (HREADYOUT_O)
    else $error("wait state inserted");
  chk_resp_okay: assert property (!HRESP_O)
    else $error("error response");
  chk_rdata_lane: assert property (HRDATA_O[31:8] == 24'h00_0000)
    else $error("read data above low byte");
  chk_rdata_hold: assert property (
    !rd_q && !$past(RESET_I) |-> $stable(HRDATA_O))
    else $error("read data moved without a read");
  chk_unmapped_zero: assert property (
    bad_q |-> HRDATA_O == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_flag0_cause: assert property (
    $fell(OVERFLOW_FLAG_T0_O)
    |-> $past(VECTOR_ACK_T0_I) || $past(wctl_q) || $past(RESET_I))
    else $error("flag 0 cleared without cause");
  chk_flag1_cause: assert property (
    $fell(OVERFLOW_FLAG_T1_O)
    |-> $past(VECTOR_ACK_T1_I) || $past(wctl_q) || $past(RESET_I))
    else $error("flag 1 cleared without cause");
  chk_reset_clear: assert property (
    $fell(RESET_I) |-> HRDATA_O == 32'h0000_0000
    && !OVERFLOW_FLAG_T0_O && !OVERFLOW_FLAG_T1_O)
    else $error("state not cleared by reset");
  chk_flag_spacing: assert property (
    $rose(OVERFLOW_FLAG_T0_O) && !$past(wctl_q) |=> quiet_t0)
    else $error("flag 0 set twice in a machine cycle");
endmodule // dtc_core_chk
bind dtc_core dtc_core_chk dtc_core_chk_inst (.SYS_CLK_I(SYS_CLK_I),
  .RESET_I(RESET_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
  .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I),
  .VECTOR_ACK_T0_I(VECTOR_ACK_T0_I), .VECTOR_ACK_T1_I(VECTOR_ACK_T1_I),
  .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
  .OVERFLOW_FLAG_T0_O(OVERFLOW_FLAG_T0_O),
  .OVERFLOW_FLAG_T1_O(OVERFLOW_FLAG_T1_O));
`default_nettype wire

// ### dtc_pin_source.sv
`timescale 1ns/100ps
`default_nettype none
module dtc_pin_source (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [3:0] num_i,
  input  wire logic       gate_t0_i,
  input  wire logic       gate_t1_i,
  output var  logic       count_pin_t0_o,
  output var  logic       count_pin_t1_o,
  output wire logic       gate_pin_t0_o,
  output wire logic       gate_pin_t1_o,
  output var  logic       done_o
);
  // gate levels as the bench asks
  assign gate_pin_t0_o = gate_t0_i;
  assign gate_pin_t1_o = gate_t1_i;
  // burst of pulses, each level held a machine cycle or more
  initial
  begin
    count_pin_t0_o = 1'b0;
    count_pin_t1_o = 1'b0;
    done_o = 1'b1;
    forever
    begin
      @(posedge clk_i);
      if (go_i)
      begin
        done_o <= 1'b0;
        repeat (num_i)
        begin
          count_pin_t0_o <= 1'b1;
          count_pin_t1_o <= 1'b1;
          repeat (12 + $urandom_range(15)) @(posedge clk_i);
          count_pin_t0_o <= 1'b0;
          count_pin_t1_o <= 1'b0;
          repeat (12 + $urandom_range(15)) @(posedge clk_i);
        end
        done_o <= 1'b1;
      end
    end
  end
endmodule // dtc_pin_source
`default_nettype wire

// ### dual_timer_counter_core_bench.sv
`include "dtc_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module dual_timer_counter_core_bench;
  logic clk = 0, rst = 1, hsel = 0, hwr = 0, go = 0, g0 = 0, g1 = 0;
  logic ack0 = 0, ack1 = 0, rdy, resp, f0, f1, p0, p1, gp0, gp1, dn;
  logic [31:0] ha = 0, hwd = 0, hrd, r;
  logic [1:0] ht = 0;
  logic [3:0] num = 0;
  logic [7:0] a, b, c;
  logic [7:0] ofs [6] = '{`DTC_OFS_MODE, `DTC_OFS_CTRL, `DTC_OFS_LOW_T0,
    `DTC_OFS_HIGH_T0, `DTC_OFS_LOW_T1, `DTC_OFS_HIGH_T1};
  int n_errors = 0, samples_checked = 0;
  // 250 MHz core clock
  initial forever #2 clk = ~clk;
  dtc_core dtc_core_inst (.SYS_CLK_I(clk), .RESET_I(rst), .HSEL_I(hsel),
    .HADDR_I(ha), .HTRANS_I(ht), .HWRITE_I(hwr), .HSIZE_I(3'b010),
    .HWDATA_I(hwd), .HREADY_I(rdy), .HRDATA_O(hrd), .HREADYOUT_O(rdy),
    .HRESP_O(resp), .COUNT_PIN_T0_I(p0), .COUNT_PIN_T1_I(p1),
    .GATE_PIN_T0_I(gp0), .GATE_PIN_T1_I(gp1), .VECTOR_ACK_T0_I(ack0),
    .VECTOR_ACK_T1_I(ack1), .OVERFLOW_FLAG_T0_O(f0),
    .OVERFLOW_FLAG_T1_O(f1));
  dtc_pin_source dtc_pin_source_inst (.clk_i(clk), .go_i(go), .num_i(num),
    .gate_t0_i(g0), .gate_t1_i(g1), .count_pin_t0_o(p0),
    .count_pin_t1_o(p1), .gate_pin_t0_o(gp0), .gate_pin_t1_o(gp1),
    .done_o(dn));
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // bounded wait for a level, timeout ends the run
  // which picks the level: 0 bus ready, 1 pin source done
  task automatic wt(input logic which, input logic v, input int lim);
    int i;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while ((which ? dn : rdy) !== v && i < lim);
    if ((which ? dn : rdy) !== v)
    begin
      n_errors++;
      $display("CHECK FAILED %0t wait timed out", $time);
      close_out;
    end
  endtask
  // mode 0 low byte after n counts: prescaler bits wrap, top three kept
  function automatic logic [7:0] m0_low(input logic [7:0] v, input int n);
    m0_low = {v[7:5], 5'(v[4:0] + n)};
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rng(input logic [31:0] got, input logic [7:0] lo, hi);
    samples_checked++;
    if ((got >= {24'h00_0000, lo} && got <= {24'h00_0000, hi}) !== 1'b1)
    begin
      n_errors++;
      $display("CHECK FAILED %0t got %h outside %h..%h", $time, got, lo, hi);
    end
  endtask
  // one single ahb-lite transfer, result in r
  task automatic bus(input logic w, input logic [7:0] ad, d);
    hsel <= 1'b1;
    ha <= {24'h00_0000, ad};
    ht <= 2'b10;
    hwr <= w;
    wt(1'b0, 1'b1, 50);
    hsel <= 1'b0;
    ht <= 2'b00;
    hwd <= {24'h00_0000, d};
    wt(1'b0, 1'b1, 50);
    r = hrd;
  endtask
  task automatic wr(input logic [7:0] ad, d);
    bus(1'b1, ad, d);
  endtask
  task automatic rd(input logic [7:0] ad, e);
    bus(1'b0, ad, 8'h00);
    cmp(r, {24'h00_0000, e});
  endtask
  // pulse burst from the pin source, then settle two machine cycles
  task automatic send(input logic [3:0] k);
    num <= k;
    go <= 1'b1;
    wt(1'b1, 1'b0, 9);
    go <= 1'b0;
    wt(1'b1, 1'b1, 1000);
    repeat (24) @(posedge clk);
  endtask
  // run four machine cycles then stop with control value v
  task automatic run4(input logic [7:0] s, v);
    wr(`DTC_OFS_CTRL, s);
    repeat (48) @(posedge clk);
    wr(`DTC_OFS_CTRL, v);
  endtask
  // main sequence
  initial
  begin
    void'($urandom(32'h9b78c25a));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    wr(8'h18, 8'hFF);
    rd(8'h18, 8'h00);
    wr(`DTC_OFS_CTRL, 8'h5F);
    rd(`DTC_OFS_CTRL, 8'h50);
    wr(`DTC_OFS_CTRL, 8'h00);
    // timer 1 gate forced on, so a random split mode cannot count
    foreach (ofs[i])
      if (i != 1)
      begin
        a = 8'($urandom);
        if (i == 0)
          a[7] = 1'b1;
        wr(ofs[i], a);
        rd(ofs[i], a);
      end
    $display("test registers done");
    wr(`DTC_OFS_MODE, 8'h09);
    wr(`DTC_OFS_LOW_T0, 8'hFE);
    wr(`DTC_OFS_HIGH_T0, 8'hFF);
    wr(`DTC_OFS_CTRL, 8'h10);
    repeat (48) @(posedge clk);
    rd(`DTC_OFS_LOW_T0, 8'hFE);
    g0 <= 1'b1;
    repeat (48) @(posedge clk);
    g0 <= 1'b0;
    bus(1'b0, `DTC_OFS_LOW_T0, 8'h00);
    rng(r, 8'h01, 8'h03);
    a = r[7:0];
    cmp(f0, 1);
    rd(`DTC_OFS_HIGH_T0, 8'h00);
    rd(`DTC_OFS_CTRL, 8'h30);
    ack0 <= 1'b1;
    @(posedge clk);
    ack0 <= 1'b0;
    @(posedge clk);
    cmp(f0, 0);
    g0 <= 1'b1;
    repeat (48) @(posedge clk);
    g0 <= 1'b0;
    bus(1'b0, `DTC_OFS_LOW_T0, 8'h00);
    rng(r, a + 8'h03, a + 8'h05);
    $display("test timer gate done");
    wr(`DTC_OFS_MODE, 8'hD5);
    for (int i = 2; i < 6; i++) wr(ofs[i], 8'h00);
    wr(`DTC_OFS_CTRL, 8'h50);
    a = 8'($urandom_range(3, 8));
    send(a[3:0]);
    rd(`DTC_OFS_LOW_T0, a);
    rd(`DTC_OFS_LOW_T1, 8'h00);
    g1 <= 1'b1;
    b = 8'($urandom_range(3, 8));
    send(b[3:0]);
    rd(`DTC_OFS_LOW_T0, a + b);
    rd(`DTC_OFS_LOW_T1, b);
    wr(`DTC_OFS_CTRL, 8'h00);
    $display("test counter done");
    // both timers in mode 0, then both in auto-reload
    wr(`DTC_OFS_MODE, 8'h00);
    for (int i = 2; i < 6; i++) wr(ofs[i], (i[0]) ? 8'h00 : 8'hFD);
    run4(8'h50, 8'h00);
    bus(1'b0, `DTC_OFS_LOW_T0, 8'h00);
    rng(r, m0_low(8'hFD, 3), m0_low(8'hFD, 5));
    rd(`DTC_OFS_HIGH_T0, 8'h01);
    bus(1'b0, `DTC_OFS_LOW_T1, 8'h00);
    rng(r, m0_low(8'hFD, 3), m0_low(8'hFD, 5));
    rd(`DTC_OFS_HIGH_T1, 8'h01);
    wr(`DTC_OFS_MODE, 8'h22);
    for (int i = 2; i < 6; i++) wr(ofs[i], (i[0]) ? 8'hF0 : 8'hFE);
    wr(`DTC_OFS_CTRL, 8'h50);
    repeat (48) @(posedge clk);
    cmp(f0, 1);
    cmp(f1, 1);
    ack0 <= 1'b1;
    ack1 <= 1'b1;
    @(posedge clk);
    ack0 <= 1'b0;
    ack1 <= 1'b0;
    @(posedge clk);
    cmp(f0, 0);
    cmp(f1, 0);
    wr(`DTC_OFS_CTRL, 8'h00);
    rd(`DTC_OFS_HIGH_T0, 8'hF0);
    rd(`DTC_OFS_HIGH_T1, 8'hF0);
    bus(1'b0, `DTC_OFS_LOW_T0, 8'h00);
    rng(r, 8'hF1, 8'hF3);
    bus(1'b0, `DTC_OFS_LOW_T1, 8'h00);
    rng(r, 8'hF1, 8'hF3);
    $display("test modes done");
    a = 8'($urandom_range(0, 240));
    b = 8'($urandom);
    c = 8'($urandom);
    wr(`DTC_OFS_MODE, 8'h33);
    wr(`DTC_OFS_HIGH_T0, a);
    wr(`DTC_OFS_LOW_T0, b);
    wr(`DTC_OFS_LOW_T1, c);
    wr(`DTC_OFS_HIGH_T1, a);
    run4(8'h40, 8'h00);
    bus(1'b0, `DTC_OFS_HIGH_T0, 8'h00);
    rng(r, a + 8'h03, a + 8'h05);
    rd(`DTC_OFS_LOW_T0, b);
    rd(`DTC_OFS_LOW_T1, c);
    rd(`DTC_OFS_HIGH_T1, a);
    $display("test split done");
    // software sets both flags with both run bits clear, then a reset clears all
    wr(`DTC_OFS_CTRL, 8'hA0);
    @(posedge clk);
    cmp(f0, 1);
    cmp(f1, 1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    cmp(f0, 0);
    cmp(f1, 0);
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    $display("test reset done");
    close_out;
  end
endmodule // dual_timer_counter_core_bench
`default_nettype wire
